/* rtl/sfwg_top.sv */
module sfwg_top
  import sfwg_pkg::*;
(
  input wire logic ref_clk, // Bus clock, 40 MHz
  input wire logic rst, // Async reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire logic sck, // Serial clock from host
  input wire logic csN, // Chip select, active low
  input wire logic si, // Serial data in
  output logic soOut, // Serial data out
  output logic soOe, // Serial out drive enable
  input wire logic holdN, // Pause, active low
  input wire logic wpN, // Write protect, active low
  output logic [ADDR_W-1:0] memAddr, // Array address
  output logic [7:0] memWrData, // Array write byte
  output logic memWrStb, // Array write, qualified by sck rise
  input wire logic [7:0] memRdData // Array read byte, async
);
  // ==========================================
  // Link domain: frame state
  sfwg_state_t state_q;
  logic [2:0] bitCnt_q;
  logic [6:0] rxSh_q;
  logic [ADDR_W-1:0] addr_q;
  logic addrHi_q;
  logic wrOk_q;
  logic loadTx_q;
  logic writeLatch_q;
  logic [1:0] guard_q;
  logic statusLockEnable_q;
  logic dropTgl_q;
  logic [1:0] wpSync_q;
  logic [1:0] haltSync_q;
  logic [7:0] txSh_q;
  logic inGuard, hardGuardMode, softGuardMode;
  // Ref domain
  logic ack_q;
  logic haltArray_q;
  logic [15:0] drops_q;
  logic [2:0] dropSync_q;
  logic [8:0] statSync1_q, statSync2_q;

  // Frame logic clears on deselect, status survives frames
  wire frameRst = rst || csN;
  wire [7:0] rxByte = {rxSh_q, si};
  wire byteEnd = holdN && (bitCnt_q == 3'h7);
  wire opcEnd = byteEnd && (state_q == ST_OPCODE);
  wire latchSet = opcEnd && (rxByte == OP_WRITE_ARM);
  wire latchClr = opcEnd && ((rxByte == OP_WRITE_DIS) || (rxByte == OP_STAT_WR) ||
                             (rxByte == OP_ARR_WR));
  wire statusWr = byteEnd && (state_q == ST_STAT_WR) && wrOk_q && softGuardMode;
  wire arrayByte = byteEnd && (state_q == ST_ARR_WR);
  wire dropByte = arrayByte && inGuard;
  wire readPhase = (state_q == ST_ARR_RD) || (state_q == ST_STAT_RD);
  wire addrDone = byteEnd && (state_q == ST_ADDR) && addrHi_q;
  wire [7:0] statusByte = {statusLockEnable_q, 3'h0, guard_q, writeLatch_q, 1'b0};
  wire [7:0] txSrc = (state_q == ST_STAT_RD) ? statusByte : memRdData;

  sfwg_guard_decode u_decode (
    .guardBits(guard_q),
    .addr(addr_q),
    .wpSyncN(wpSync_q[1]),
    .lockEn(statusLockEnable_q),
    .inGuard(inGuard),
    .hardGuardMode(hardGuardMode),
    .softGuardMode(softGuardMode)
  );

  // ==========================================
  // Next state from the completed byte
  sfwg_state_t nextState;
  always_comb begin
    nextState = state_q;
    if (byteEnd) begin
      unique case (state_q)
        ST_OPCODE: begin
          unique case (rxByte)
            OP_STAT_RD: nextState = ST_STAT_RD;
            OP_STAT_WR: nextState = ST_STAT_WR;
            OP_ARR_RD, OP_ARR_WR: nextState = ST_ADDR;
            default: nextState = ST_DONE;
          endcase
        end
        ST_ADDR: begin
          if (addrHi_q) begin
            nextState = wrOk_q ? ST_ARR_WR : ST_ARR_RD;
          end
        end
        ST_STAT_WR: nextState = ST_DONE;
        ST_ARR_WR, ST_ARR_RD, ST_STAT_RD, ST_DONE: nextState = state_q;
      endcase
    end
  end

  // Unknown opcodes fall into ST_DONE, which ignores the rest
  // Pause holds every frame register, so the transfer resumes in place
  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      state_q <= ST_OPCODE;
      bitCnt_q <= 3'h0;
      rxSh_q <= 7'h00;
      addrHi_q <= 1'b0;
      loadTx_q <= 1'b0;
    end else if (holdN) begin
      state_q <= nextState;
      bitCnt_q <= bitCnt_q + 3'h1;
      rxSh_q <= rxByte[6:0];
      addrHi_q <= (state_q == ST_ADDR) && byteEnd ? 1'b1 : addrHi_q;
      loadTx_q <= (opcEnd && rxByte == OP_STAT_RD) || (addrDone && !wrOk_q) ||
                  (byteEnd && readPhase);
    end
  end

  // Write permission is captured from the latch when the opcode lands
  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      wrOk_q <= 1'b0;
    end else if (opcEnd) begin
      wrOk_q <= writeLatch_q && ((rxByte == OP_STAT_WR) || (rxByte == OP_ARR_WR));
    end
  end

  // Address shifts in over 16 bits, upper 4 fall off
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
    end else if (holdN && state_q == ST_ADDR) begin
      addr_q <= {addr_q[ADDR_W-2:0], si};
    end else if (byteEnd && (state_q == ST_ARR_WR || state_q == ST_ARR_RD)) begin
      addr_q <= addr_q + 12'h001;
    end
  end

  // ==========================================
  // Status register, cleared only by rst
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      writeLatch_q <= 1'b0;
      guard_q <= GUARD_RESET;
      statusLockEnable_q <= LOCK_RESET;
    end else begin
      if (latchSet) begin
        writeLatch_q <= 1'b1;
      end else if (latchClr) begin
        writeLatch_q <= 1'b0;
      end
      if (statusWr) begin
        guard_q <= {rxByte[STAT_GUARD_HI_POS], rxByte[STAT_GUARD_LO_POS]};
        statusLockEnable_q <= rxByte[STAT_LOCK_POS];
      end
    end
  end

  // Pins sampled on the link clock; wp must settle before the status byte
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      wpSync_q <= 2'h3;
      haltSync_q <= 2'h0;
      dropTgl_q <= 1'b0;
    end else begin
      wpSync_q <= {wpSync_q[0], wpN};
      haltSync_q <= {haltSync_q[0], haltArray_q};
      dropTgl_q <= dropByte ? !dropTgl_q : dropTgl_q;
    end
  end

  assign memAddr = addr_q;
  assign memWrData = rxByte;
  assign memWrStb = arrayByte && wrOk_q && !inGuard && !haltSync_q[1];

  // ==========================================
  // Output shifter on the falling edge
  always_ff @(negedge sck or posedge frameRst) begin
    if (frameRst) begin
      txSh_q <= 8'h00;
    end else if (holdN) begin
      txSh_q <= loadTx_q ? txSrc : {txSh_q[6:0], 1'b0};
    end
  end

  assign soOut = txSh_q[7];
  assign soOe = !csN && holdN && readPhase;

  // ==========================================
  // Bus slave, one wait state
  wire wbReq = wb_cyc_i && wb_stb_i;
  // Write lands on the ack edge, while the master still holds the request
  wire wbWrCtrl = wbReq && wb_we_i && ack_q && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
  wire dropPulse = dropSync_q[2] ^ dropSync_q[1];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      haltArray_q <= CTRL_HALT_RESET;
      drops_q <= DROPS_RESET;
      dropSync_q <= 3'h0;
      statSync1_q <= '0;
      statSync2_q <= '0;
    end else begin
      ack_q <= wbReq && !ack_q;
      haltArray_q <= wbWrCtrl ? wb_dat_i[CTRL_HALT_POS] : haltArray_q;
      dropSync_q <= {dropSync_q[1:0], dropTgl_q};
      drops_q <= dropPulse ? drops_q + 16'h0001 : drops_q;
      // Bits are independent levels; a read mid-update may mix old and new
      statSync1_q <= {hardGuardMode, statusByte};
      statSync2_q <= statSync1_q;
    end
  end

  wire [31:0] rdStatus = {23'h0, statSync2_q};
  wire [31:0] rdCtrl = {31'h0, haltArray_q};
  wire [31:0] rdDrops = {16'h0, drops_q};
  assign wb_ack_o = ack_q;
  assign wb_dat_o = !ack_q ? 32'h0 :
                    (wb_adr_i == REG_STATUS) ? rdStatus :
                    (wb_adr_i == REG_CTRL) ? rdCtrl :
                    (wb_adr_i == REG_DROPS) ? rdDrops : 32'h0;

  // ==========================================
  // Checks on the link domain
  a_guard_all: assert property (@(posedge sck) disable iff (rst || csN)
    arrayByte && guard_q == 2'h3 |-> !memWrStb)
    else $error("write reached array with whole array guarded");
  a_guard_quarter: assert property (@(posedge sck) disable iff (rst || csN)
    arrayByte && guard_q == 2'h1 && addr_q >= 12'hC00 |-> !memWrStb)
    else $error("write reached guarded upper quarter");
  a_guard_open: assert property (@(posedge sck) disable iff (rst || csN)
    arrayByte && guard_q == 2'h0 && wrOk_q && !haltSync_q[1] |-> memWrStb)
    else $error("armed write dropped with no guard");
  // Status outlives the frame, so only rst cancels a check on the next edge
  a_soft_accept: assert property (@(posedge sck) disable iff (rst)
    statusWr |=> guard_q == $past(rxByte[3:2]) && statusLockEnable_q == $past(rxByte[7]))
    else $error("accepted status write not stored");
  a_hard_reject: assert property (@(posedge sck) disable iff (rst)
    byteEnd && state_q == ST_STAT_WR && hardGuardMode |=> $stable(guard_q))
    else $error("guard bits changed in hard mode");
  a_pause_freeze: assert property (@(posedge sck) disable iff (rst || csN)
    !holdN |=> $stable(bitCnt_q) && $stable(state_q) && $stable(addr_q))
    else $error("transfer state moved during pause");
  a_pause_release: assert property (@(posedge sck) disable iff (rst || csN)
    !holdN |-> !soOe && !memWrStb && !statusWr)
    else $error("output driven or input taken while paused");
  a_latch_needed: assert property (@(posedge sck) disable iff (rst || csN)
    opcEnd && !writeLatch_q && rxByte != OP_WRITE_ARM |=> !wrOk_q ##1 !writeLatch_q [*2])
    else $error("write permitted without armed latch");
  a_opcode_status: assert property (@(posedge sck) disable iff (rst || csN)
    opcEnd && rxByte == 8'h01 |=> state_q == ST_STAT_WR)
    else $error("status write opcode not decoded");
  a_addr_advance: assert property (@(posedge sck) disable iff (rst || csN)
    arrayByte |=> addr_q == $past(addr_q) + 12'h001)
    else $error("address did not advance after burst byte");
  a_guard_half: assert property (@(posedge sck) disable iff (rst || csN)
    arrayByte && guard_q == 2'h2 && addr_q >= 12'h800 |-> !memWrStb)
    else $error("write reached guarded upper half");
  a_guard_low_open: assert property (@(posedge sck) disable iff (rst || csN)
    arrayByte && guard_q == 2'h1 && addr_q < 12'hC00 && wrOk_q && !haltSync_q[1] |-> memWrStb)
    else $error("armed write dropped below guarded quarter");
  a_hard_no_write: assert property (@(posedge sck) disable iff (rst || csN)
    hardGuardMode |-> !statusWr)
    else $error("status write accepted in hard mode");
  a_hard_decode: assert property (@(posedge sck) disable iff (rst)
    !wpSync_q[1] && statusLockEnable_q |-> hardGuardMode && !softGuardMode)
    else $error("pin and lock bit did not select hard mode");
  a_read_drive: assert property (@(posedge sck) disable iff (rst || csN)
    readPhase && holdN |-> soOe)
    else $error("read data not driven outside pause");
  a_latch_set: assert property (@(posedge sck) disable iff (rst)
    latchSet |=> writeLatch_q)
    else $error("arm command did not set the latch");
  a_latch_clear: assert property (@(posedge sck) disable iff (rst)
    opcEnd && (rxByte == OP_STAT_WR || rxByte == OP_ARR_WR) |=> !writeLatch_q)
    else $error("latch survived a write opcode");
  a_latch_disarm: assert property (@(posedge sck) disable iff (rst)
    opcEnd && rxByte == OP_WRITE_DIS |=> !writeLatch_q)
    else $error("disarm command left the latch set");
  a_halt_block: assert property (@(posedge sck) disable iff (rst || csN)
    haltSync_q[1] |-> !memWrStb)
    else $error("array write passed while halted");
  a_drop_toggle: assert property (@(posedge sck) disable iff (rst)
    dropByte |=> dropTgl_q != $past(dropTgl_q))
    else $error("dropped byte not counted");

  c_guard_drop: cover property (@(posedge sck) disable iff (rst || csN) dropByte);
  c_status_hard: cover property (@(posedge sck) disable iff (rst || csN)
    byteEnd && state_q == ST_STAT_WR && hardGuardMode);
  c_pause_read: cover property (@(posedge sck) disable iff (rst || csN)
    readPhase && !holdN ##1 holdN);
  c_array_write: cover property (@(posedge sck) disable iff (rst || csN) memWrStb);
  c_status_accept: cover property (@(posedge sck) disable iff (rst || csN) statusWr);

  // ==========================================
  // Checks on the bus side
  a_ack_single: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge stood for more than one cycle");
  a_dat_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data shown without acknowledge");
endmodule : sfwg_top

/* rtl/sfwg_guard.sv */
// ==========================================
// Notes on behaviour
// - Guard bits pick protected upper address range
// - Soft mode: armed status write is accepted
// - Hard mode: every status write is rejected
// - Pause freezes transfer, resumes where stopped
// - Paused: output released, input bits ignored
// - Writes need latch armed beforehand
// - Status write opcode 01 updates three bits
package sfwg_pkg;
  // ==========================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  // ==========================================
  // Array and guard ranges
  localparam int ADDR_W = 12;
  localparam logic [11:0] GUARD_QUARTER_BASE = 12'hC00;
  localparam logic [11:0] GUARD_HALF_BASE = 12'h800;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  // ==========================================
  // Status byte layout
  localparam int STAT_LOCK_POS = 7;
  localparam int STAT_GUARD_HI_POS = 3;
  localparam int STAT_GUARD_LO_POS = 2;
  localparam int STAT_LATCH_POS = 1;
  localparam logic [1:0] GUARD_RESET = 2'h0;
  localparam logic LOCK_RESET = 1'b0;
  // ==========================================
  // Bus map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_DROPS = 4'h8;
  localparam int CTRL_HALT_POS = 0;
  localparam int STATUS_HARD_POS = 8;
  localparam logic CTRL_HALT_RESET = 1'b0;
  localparam logic [15:0] DROPS_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_ARR_WR, ST_ARR_RD, ST_STAT_WR, ST_STAT_RD, ST_DONE
  } sfwg_state_t;
endpackage : sfwg_pkg

module sfwg_guard_decode
  import sfwg_pkg::*;
(
  input wire logic [1:0] guardBits, // Guard range field
  input wire logic [ADDR_W-1:0] addr, // Current array address
  input wire logic wpSyncN, // Write protect pin, synchronised
  input wire logic lockEn, // Status lock enable bit
  output logic inGuard, // Address is protected
  output logic hardGuardMode, // Status register locked
  output logic softGuardMode // Status register writable when armed
);
  wire quarterHit = addr >= GUARD_QUARTER_BASE;
  wire halfHit = addr >= GUARD_HALF_BASE;
  assign inGuard = (guardBits == GUARD_NONE) ? 1'b0 :
                   (guardBits == GUARD_QUARTER) ? quarterHit :
                   (guardBits == GUARD_HALF) ? halfHit : 1'b1;
  assign hardGuardMode = !wpSyncN && lockEn;
  assign softGuardMode = !hardGuardMode;
endmodule : sfwg_guard_decode

/* verification/sfwg_host_model.sv */
module sfwg_host_model (
  output logic sck, // Serial clock, still between frames
  output logic csN, // Select, active low
  output logic si, // Serial data to device
  output logic holdN, // Pause, active low
  input wire logic soWire // Resolved serial out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'h0;
    csN = 1'h1;
    si = 1'h0;
    holdN = 1'h1;
  end
  // ====
  // Mode 0 bit timing, 6 ns per bit
  task automatic bitx(input logic b);
    si = b;
    #3 sck = 1'h1;
    #3 sck = 1'h0;
  endtask : bitx
  task automatic sendByte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bitx(v[i]);
  endtask : sendByte
  task automatic recvByte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      #3 sck = 1'h1;
      v[i] = soWire;
      #3 sck = 1'h0;
    end
  endtask : recvByte
  // Select stays low; garbage bits must be ignored
  task automatic pauseOn(input int n);
    // Pause only while the clock is low, clear of its falling edge
    #1 holdN = 1'h0;
    repeat (n) bitx(~si);
  endtask : pauseOn
  task automatic pauseOff;
    #2 holdN = 1'h1;
    #2;
  endtask : pauseOff
  task automatic frameOpen;
    #4 csN = 1'h0;
    #4;
  endtask : frameOpen
  // Idle data line flips so a stale bit never looks valid
  task automatic frameClose;
    #4 csN = 1'h1;
    si = ~si;
    #8;
  endtask : frameClose
endmodule : sfwg_host_model

/* verification/test_spi_fram_write_guard_hold.sv */
module test_spi_fram_write_guard_hold
  import sfwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
  typedef struct packed {
    logic [1:0] g;
    logic [11:0] a;
    logic [1:0] n;
    logic [11:0] last;
  } sfwg_row_t;
  // Guard field, burst start, strobes expected, last address written
  sfwg_row_t rows [5] = '{'{2'h1, 12'hBFF, 2'h1, 12'hBFF}, '{2'h2, 12'h7FF, 2'h1, 12'h7FF},
    '{2'h3, 12'h000, 2'h0, 12'h000}, '{2'h0, 12'hFFE, 2'h2, 12'hFFF},
    '{2'h1, 12'hFFF, 2'h1, 12'h000}};
  logic ref_clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, wpN = 1'h1;
  logic [3:0] adr = 4'h0, sel = 4'h1;
  logic [31:0] wdat = 32'h0, rdat, datO;
  logic ack, sck, csN, si, soOut, soOe, holdN, memWrStb;
  logic [11:0] memAddr, lastAddr = 12'h0;
  logic [7:0] memWrData, lastData = 8'h0, b;
  int num_errors = 0, cmp_count = 0, stbCount = 0, d0;
  // Released line shows the inverse, so a missing drive reads wrong
  wire soWire = soOe ? soOut : !soOut;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  sfwg_top sfwg_top_inst (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO),
    .wb_ack_o(ack), .sck(sck), .csN(csN), .si(si), .soOut(soOut), .soOe(soOe),
    .holdN(holdN), .wpN(wpN), .memAddr(memAddr), .memWrData(memWrData),
    .memWrStb(memWrStb), .memRdData(memAddr[7:0] ^ 8'h3C));
  sfwg_host_model sfwg_host_model_inst (.sck(sck), .csN(csN), .si(si), .holdN(holdN),
    .soWire(soWire));
  always @(posedge sck) begin
    if (memWrStb === 1'h1) begin
      stbCount++;
      lastAddr = memAddr;
      lastData = memWrData;
    end
  end
  // ====
  // Bus and frame tasks
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask : endTest
  task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rdat = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
    @(posedge ref_clk);
  endtask : wbXfer
  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    wbXfer(1'h0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rdChk
  task automatic cmd(input logic [7:0] op);
    sfwg_host_model_inst.frameOpen();
    sfwg_host_model_inst.sendByte(op);
    sfwg_host_model_inst.frameClose();
  endtask : cmd
  task automatic setStat(input logic arm, input logic [7:0] v);
    if (arm) cmd(OP_WRITE_ARM);
    sfwg_host_model_inst.frameOpen();
    sfwg_host_model_inst.sendByte(OP_STAT_WR);
    sfwg_host_model_inst.sendByte(v);
    sfwg_host_model_inst.frameClose();
  endtask : setStat
  // Drop counter crosses domains, so allow it to settle
  task automatic wrArr(input logic [11:0] a, input int n);
    sfwg_host_model_inst.frameOpen();
    sfwg_host_model_inst.sendByte(OP_ARR_WR);
    sfwg_host_model_inst.sendByte({4'h0, a[11:8]});
    sfwg_host_model_inst.sendByte(a[7:0]);
    repeat (n) sfwg_host_model_inst.sendByte(8'h5A);
    sfwg_host_model_inst.frameClose();
    repeat (10) @(posedge ref_clk);
  endtask : wrArr
  // ====
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    rdChk(REG_STATUS, 32'h0);
    rdChk(REG_DROPS, 32'h0);
    wbXfer(1'h1, REG_CTRL, 32'h1);
    rdChk(REG_CTRL, 32'h1);
    cmd(OP_WRITE_ARM);
    stbCount = 0;
    wrArr(12'h010, 1);
    `CHK(stbCount, 0)
    wbXfer(1'h1, REG_CTRL, 32'h0);
    rdChk(4'hC, 32'h0);
    endTest("reset");
    foreach (rows[i]) begin
      setStat(1'h1, {4'h0, rows[i].g, 2'h0});
      rdChk(REG_STATUS, {28'h0, rows[i].g, 2'h0});
      wbXfer(1'h0, REG_DROPS, 32'h0);
      d0 = int'(rdat[15:0]);
      stbCount = 0;
      cmd(OP_WRITE_ARM);
      wrArr(rows[i].a, 2);
      `CHK(stbCount, int'(rows[i].n))
      if (rows[i].n != 2'h0) `CHK(lastAddr, rows[i].last)
      rdChk(REG_DROPS, 32'(d0 + 2 - int'(rows[i].n)));
    end
    endTest("rows");
    stbCount = 0;
    wrArr(12'h010, 1);
    `CHK(stbCount, 0)
    setStat(1'h0, 8'h0C);
    rdChk(REG_STATUS, 32'h4);
    cmd(OP_WRITE_ARM);
    rdChk(REG_STATUS, 32'h6);
    cmd(OP_WRITE_DIS);
    rdChk(REG_STATUS, 32'h4);
    stbCount = 0;
    wrArr(12'h010, 1);
    `CHK(stbCount, 0)
    sfwg_host_model_inst.frameOpen();
    sfwg_host_model_inst.sendByte(OP_ARR_RD);
    sfwg_host_model_inst.sendByte(8'h00);
    sfwg_host_model_inst.sendByte(8'hF0);
    sfwg_host_model_inst.recvByte(b);
    sfwg_host_model_inst.frameClose();
    `CHK(b, 8'hCC)
    endTest("unarmed");
    setStat(1'h1, 8'h84);
    rdChk(REG_STATUS, 32'h84);
    @(posedge ref_clk) wpN <= 1'h0;
    setStat(1'h1, 8'h00);
    rdChk(REG_STATUS, 32'h184);
    @(posedge ref_clk) wpN <= 1'h1;
    setStat(1'h1, 8'h0C);
    rdChk(REG_STATUS, 32'hC);
    endTest("protect");
    setStat(1'h1, 8'h00);
    cmd(OP_WRITE_ARM);
    stbCount = 0;
    sfwg_host_model_inst.frameOpen();
    sfwg_host_model_inst.sendByte(OP_ARR_WR);
    sfwg_host_model_inst.sendByte(8'h01);
    sfwg_host_model_inst.sendByte(8'h23);
    for (int i = 7; i >= 0; i--) begin
      if (i == 3) begin
        sfwg_host_model_inst.pauseOn(5);
        `CHK(soOe, 1'h0)
        sfwg_host_model_inst.pauseOff();
      end
      sfwg_host_model_inst.bitx(b8(i));
    end
    sfwg_host_model_inst.frameClose();
    `CHK(lastAddr, 12'h123)
    `CHK(lastData, 8'hA5)
    `CHK(stbCount, 1)
    cmd(OP_WRITE_ARM);
    sfwg_host_model_inst.frameOpen();
    sfwg_host_model_inst.sendByte(OP_STAT_RD);
    `CHK(soOe, 1'h1)
    sfwg_host_model_inst.pauseOn(3);
    `CHK(soOe, 1'h0)
    sfwg_host_model_inst.pauseOff();
    sfwg_host_model_inst.recvByte(b);
    sfwg_host_model_inst.frameClose();
    `CHK(b, 8'h02)
    endTest("pause");
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    rdChk(REG_STATUS, 32'h0);
    endTest("reset again");
    close_out();
  end
  function automatic logic b8(input int i);
    logic [7:0] v;
    v = 8'hA5;
    return v[i];
  endfunction : b8
endmodule : test_spi_fram_write_guard_hold
